// File: bench/compare_channel_props.sv
`timescale 1ns/1ps
// Port-level checks of the compare channel
module compare_channel_props #(
  parameter CHANNEL_INDEX = 1
) (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire fault_input_a,
  input wire fault_input_b,
  input wire compare_output_pin,
  input wire compare_output_oe
);
  logic [7:0] aw_r; // Last write address taken
  logic [2:0] wd_r; // Last mode bits taken
  logic [2:0] mode_r; // Mode once the write is answered
  wire flt_n = (CHANNEL_INDEX <= 4) ? fault_input_a : fault_input_b; // Governing fault
  // Shadow of the mode field, late on purpose so it never leads the design
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_r <= 8'h00;
      wd_r <= 3'h0;
      mode_r <= 3'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) aw_r <= s_axi_awaddr[7:0];
      if (s_axi_wvalid && s_axi_wready) wd_r <= s_axi_wdata[2:0];
      if (s_axi_bvalid && s_axi_bready && aw_r == 8'h00) mode_r <= wd_r;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_oe_off: assert property (mode_r == 3'h0 |-> !compare_output_oe)
    else $error("pin driven while disabled");
  a_oe_on: assert property (mode_r != 3'h0 |-> compare_output_oe)
    else $error("pin released while enabled");
  a_fault_force: assert property ((mode_r == 3'h7 && !flt_n) [*6] |-> !compare_output_pin)
    else $error("fault did not force pin low");
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
  a_write_answer: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("write not answered");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
endmodule
bind output_compare_channel compare_channel_props #(.CHANNEL_INDEX(CHANNEL_INDEX))
  compare_channel_props_i (.*);

// File: bench/fault_source.sv
`timescale 1ns/1ps
// Pulled-up fault line outside the chip, pulled low on command
module fault_source (
  input wire aclk,
  input wire compare_output_pin,
  input wire trip,
  output logic fault_n
);
  // Idle level is the pull-up; low only while tripped
  always @(posedge aclk) fault_n <= !trip;
endmodule

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [15:0] first_timebase = 16'hFFF0, second_timebase = 16'hFFF0;
  logic first_period_roll = 1'h0, second_period_roll = 1'h0, cpu_idle = 1'h0;
  logic fault_input_b = 1'h1, trip = 1'h0;
  wire fault_input_a, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire compare_output_pin, compare_output_oe, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int fails = 0, checked = 0, i;
  logic [31:0] rv;
  logic [1:0] rr;
  logic [23:0] r;
  // Rows: mode+select nibble, primary value, then pulse mask, start level, end level
  logic [23:0] rows [0:9] = '{24'h200105, 24'h300104, 24'h300109, 24'h400206, 24'h600305,
    24'h600306, 24'h800405, 24'hA00505, 24'hC00603, 24'hC00000};
  output_compare_channel #(.CHANNEL_INDEX(1)) output_compare_channel_i (.*);
  fault_source fault_source_i (.aclk(aclk), .compare_output_pin(compare_output_pin),
    .trip(trip), .fault_n(fault_input_a));
  // 40 MHz clock
  initial begin
    forever #12.5 aclk = !aclk;
  end
  task stop_test;
    if (fails == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Bus write; both halves offered together, each released when taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic b;
    b = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 64 && !b; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) begin
        b = 1'h1;
        s_axi_bready <= 1'h0;
      end
    end
    if (!b) begin
      fails++;
      stop_test();
    end
  endtask
  // Bus read; result lands in rv and rr
  task rd(input logic [7:0] a);
    int n;
    logic b;
    b = 1'h0;
    @(posedge aclk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 64 && !b; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) begin
        b = 1'h1;
        rv = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'h0;
      end
    end
    if (!b) begin
      fails++;
      stop_test();
    end
  endtask
  // One-cycle match on the chosen timebases, then back to idle value
  task pulse(input logic [1:0] w, input logic [15:0] v);
    @(posedge aclk);
    if (w[0]) first_timebase <= v;
    if (w[1]) second_timebase <= v;
    @(posedge aclk);
    first_timebase <= 16'hFFF0;
    second_timebase <= 16'hFFF0;
    cyc(4);
  endtask
  initial begin
    cyc(8);
    aresetn <= 1'h1;
    rd(8'h00);
    chk(rv, 32'h0);
    rd(8'h20);
    chk({30'h0, rr}, 32'h2);
    for (i = 0; i < 10; i++) begin
      r = rows[i];
      wr(8'h04, {16'h0, r[19:4]});
      wr(8'h08, 32'h0000FFFF);
      wr(8'h00, {28'h0, r[20], r[23:21]});
      cyc(4);
      chk({31'h0, compare_output_pin}, {31'h0, r[1]});
      chk({31'h0, compare_output_oe}, 32'h1);
      pulse(r[3:2], r[19:4]);
      chk({31'h0, compare_output_pin}, {31'h0, r[0]});
    end
    rd(8'h0C);
    chk(rv, 32'h3);
    wr(8'h08, 32'h8);
    @(posedge aclk) first_period_roll <= 1'h1;
    @(posedge aclk) first_period_roll <= 1'h0;
    cyc(4);
    chk({31'h0, compare_output_pin}, 32'h1);
    pulse(2'h1, 16'h0008);
    chk({31'h0, compare_output_pin}, 32'h0);
    wr(8'h04, 32'h10);
    wr(8'h08, 32'hFFFF);
    @(posedge aclk) cpu_idle <= 1'h1;
    wr(8'h00, 32'h2001);
    pulse(2'h1, 16'h0010);
    chk({31'h0, compare_output_pin}, 32'h0);
    @(posedge aclk) cpu_idle <= 1'h0;
    pulse(2'h1, 16'h0010);
    chk({31'h0, compare_output_pin}, 32'h1);
    wr(8'h0C, 32'h7);
    wr(8'h10, 32'h4);
    wr(8'h00, 32'h7);
    cyc(4);
    chk({31'h0, compare_output_pin}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    @(posedge aclk) trip <= 1'h1;
    cyc(8);
    chk({31'h0, compare_output_pin}, 32'h0);
    chk({31'h0, irq}, 32'h1);
    rd(8'h00);
    chk({31'h0, rv[4]}, 32'h1);
    @(posedge aclk) trip <= 1'h0;
    cyc(8);
    chk({31'h0, compare_output_pin}, 32'h0);
    wr(8'h0C, 32'h4);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    wr(8'h00, 32'h7);
    rd(8'h00);
    chk({31'h0, rv[4]}, 32'h0);
    wr(8'h00, 32'h0);
    cyc(4);
    chk({31'h0, compare_output_oe}, 32'h0);
    wr(8'h00, 32'h1);
    @(posedge aclk) aresetn <= 1'h0;
    cyc(2);
    chk({30'h0, compare_output_oe, irq}, 32'h0);
    @(posedge aclk) aresetn <= 1'h1;
    rd(8'h00);
    chk(rv, 32'h0);
    stop_test();
  end
endmodule

// File: logic/compare_channel_regs.vh
// Summary of operation
// - Timebase select bit 3 picks second timebase
// - Mode chooses one or two compare values
// - Pin changes when timer equals compare value
// - Mode bits 2-0; 000 disables, GPIO owns pin
// - Mode 001: start low, match drives high
// - Mode 010: start high, match low, falling irq
// - Mode 011: keep level, toggle, both-edge irq
// - Mode 100: start low, one pulse, falling irq
// - Mode 101: start low, pulse train, falling irq
// - Mode 110: PWM, fault ignored, no irq
// - Mode 111: PWM with fault, fault-fall irq
// - Fault A governs channels 1-4, B 5-8
// - Fault flag bit 4, cleared by control write, mode 111
// - Idle bit 13 halts channel during idle
`ifndef COMPARE_CHANNEL_REGS_VH
`define COMPARE_CHANNEL_REGS_VH
// Register byte offsets
`define CCH_CTRL_OFS 8'h00
`define CCH_PRI_OFS 8'h04
`define CCH_SEC_OFS 8'h08
`define CCH_STAT_OFS 8'h0C
`define CCH_MASK_OFS 8'h10
// Control field positions
`define CCH_MODE_HI 2
`define CCH_MODE_LO 0
`define CCH_TSEL_BIT 3
`define CCH_FLT_BIT 4
`define CCH_IDLE_BIT 13
// Writable control bits
`define CCH_CTRL_WMASK 16'h200F
`define CCH_CTRL_RST 16'h0000
// Mode codes
`define CCH_M_OFF 3'h0
`define CCH_M_SETHI 3'h1
`define CCH_M_SETLO 3'h2
`define CCH_M_TOGGLE 3'h3
`define CCH_M_ONEPULSE 3'h4
`define CCH_M_PULSES 3'h5
`define CCH_M_PWM 3'h6
`define CCH_M_PWMF 3'h7
// Interrupt status bits
`define CCH_IRQ_FALL 0
`define CCH_IRQ_RISE 1
`define CCH_IRQ_FAULT 2
`define CCH_IRQ_W 3
`endif

// File: logic/output_compare_channel.v
`timescale 1ns/1ps
`include "compare_channel_regs.vh"
// One output compare channel with AXI4-Lite register access
module output_compare_channel #(
  parameter CHANNEL_INDEX = 1
) (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [15:0] first_timebase,
  input wire first_period_roll,
  input wire [15:0] second_timebase,
  input wire second_period_roll,
  input wire cpu_idle,
  input wire fault_input_a,
  input wire fault_input_b,
  output reg compare_output_pin,
  output reg compare_output_oe,
  output reg irq
);
  // Control, compare and interrupt registers
  reg [15:0] ctrl_r;
  reg [15:0] pri_r;
  reg [15:0] sec_r;
  reg [15:0] duty_r;
  reg [`CCH_IRQ_W-1:0] stat_r;
  reg [`CCH_IRQ_W-1:0] mask_r;
  reg flt_r;
  reg pin_r;
  reg pin_d_r;
  reg flt_d_r;
  reg done_r;
  reg mode_new_r;
  // Write channel latches
  reg aw_held_r;
  reg w_held_r;
  reg [7:0] waddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  // Synchronised fault level
  wire fault_a_lvl;
  wire fault_b_lvl;
  wire fault_lvl;
  wire [2:0] mode;
  wire [15:0] tmr;
  wire roll;
  wire run;
  wire pri_hit;
  wire sec_hit;
  wire do_write;
  wire [`CCH_IRQ_W-1:0] ev;
  reg [15:0] ctrl_nxt;
  reg pin_nxt;

  // Merge write-enabled bytes into a 16-bit register
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] d;
    input [3:0] s;
    begin
      merge16 = old;
      if (s[0]) merge16[7:0] = d[7:0];
      if (s[1]) merge16[15:8] = d[15:8];
    end
  endfunction

  pin_sync u_sync_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(fault_input_a),
    .level_r(fault_a_lvl)
  );
  pin_sync u_sync_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(fault_input_b),
    .level_r(fault_b_lvl)
  );

  // Channels one to four follow fault A, five to eight fault B
  assign fault_lvl = (CHANNEL_INDEX <= 4) ? fault_a_lvl : fault_b_lvl;
  assign mode = ctrl_r[`CCH_MODE_HI:`CCH_MODE_LO];
  // Timebase routing
  assign tmr = ctrl_r[`CCH_TSEL_BIT] ? second_timebase : first_timebase;
  assign roll = ctrl_r[`CCH_TSEL_BIT] ? second_period_roll : first_period_roll;
  // Idle halt gate
  assign run = !(cpu_idle && ctrl_r[`CCH_IDLE_BIT]);
  assign pri_hit = run && (tmr == pri_r);
  assign sec_hit = run && (tmr == sec_r);
  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;

  // Next pin level per mode
  always @* begin
    pin_nxt = pin_r;
    if (mode_new_r) begin
      // Initial level on mode entry
      case (mode)
        `CCH_M_SETLO: pin_nxt = 1'b1;
        `CCH_M_TOGGLE: pin_nxt = pin_r;
        `CCH_M_PWM, `CCH_M_PWMF: pin_nxt = (pri_r != 16'h0000);
        default: pin_nxt = 1'b0;
      endcase
    end else if (run) begin
      case (mode)
        `CCH_M_SETHI: if (pri_hit) pin_nxt = 1'b1;
        `CCH_M_SETLO: if (pri_hit) pin_nxt = 1'b0;
        `CCH_M_TOGGLE: if (pri_hit) pin_nxt = ~pin_r;
        `CCH_M_ONEPULSE, `CCH_M_PULSES: begin
          // Secondary match ends the pulse, primary starts it
          if (sec_hit && pin_r) pin_nxt = 1'b0;
          else if (pri_hit && !pin_r && !done_r) pin_nxt = 1'b1;
        end
        `CCH_M_PWM, `CCH_M_PWMF: begin
          // Rollover starts the period, duty match ends it
          if (roll) pin_nxt = (sec_r != 16'h0000);
          else if (tmr == duty_r) pin_nxt = 1'b0;
        end
        default: pin_nxt = pin_r;
      endcase
    end
    if (mode == `CCH_M_PWMF && (flt_r || !fault_lvl)) pin_nxt = 1'b0;
  end

  // Control write: status bit is read-only
  always @* begin
    ctrl_nxt = (merge16(ctrl_r, wdata_r, wstrb_r) & `CCH_CTRL_WMASK);
  end

  // Events from pin and fault edges
  assign ev[`CCH_IRQ_FALL] = pin_d_r && !pin_r &&
    (mode == `CCH_M_SETLO || mode == `CCH_M_TOGGLE ||
     mode == `CCH_M_ONEPULSE || mode == `CCH_M_PULSES);
  assign ev[`CCH_IRQ_RISE] = !pin_d_r && pin_r && (mode == `CCH_M_TOGGLE);
  assign ev[`CCH_IRQ_FAULT] = flt_d_r && !fault_lvl && (mode == `CCH_M_PWMF);

  // Channel core and register file
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= `CCH_CTRL_RST;
      pri_r <= 16'h0000;
      sec_r <= 16'h0000;
      duty_r <= 16'h0000;
      stat_r <= 3'h0;
      mask_r <= 3'h0;
      flt_r <= 1'b0;
      pin_r <= 1'b0;
      pin_d_r <= 1'b0;
      flt_d_r <= 1'b1;
      done_r <= 1'b0;
      mode_new_r <= 1'b0;
      compare_output_pin <= 1'b0;
      compare_output_oe <= 1'b0;
      irq <= 1'b0;
    end else begin
      pin_r <= pin_nxt;
      pin_d_r <= pin_r;
      flt_d_r <= fault_lvl;
      mode_new_r <= 1'b0;
      // Single-pulse mode stops after its one falling edge
      if (mode == `CCH_M_ONEPULSE && pin_r && !pin_nxt) done_r <= 1'b1;
      // Duty latched at period rollover
      if (run && roll && (mode == `CCH_M_PWM || mode == `CCH_M_PWMF)) begin
        duty_r <= sec_r;
      end
      // Fault latch, cleared only by mode rewrite
      if (mode == `CCH_M_PWMF && !fault_lvl) flt_r <= 1'b1;
      // Pin driven only while a mode is active
      compare_output_pin <= pin_nxt;
      compare_output_oe <= (mode != `CCH_M_OFF);
      // Sticky status, set wins over write-one clear
      if (do_write && waddr_r == `CCH_STAT_OFS) begin
        stat_r <= (stat_r & ~wdata_r[`CCH_IRQ_W-1:0]) | ev;
      end else begin
        stat_r <= stat_r | ev;
      end
      irq <= |((stat_r | ev) & mask_r);
      if (do_write) begin
        // Register decode
        if (waddr_r == `CCH_CTRL_OFS) begin
          ctrl_r <= ctrl_nxt;
          mode_new_r <= 1'b1;
          done_r <= 1'b0;
          flt_r <= 1'b0;
          duty_r <= sec_r;
        end else if (waddr_r == `CCH_PRI_OFS) begin
          pri_r <= merge16(pri_r, wdata_r, wstrb_r);
        end else if (waddr_r == `CCH_SEC_OFS) begin
          sec_r <= merge16(sec_r, wdata_r, wstrb_r);
        end else if (waddr_r == `CCH_MASK_OFS) begin
          if (wstrb_r[0]) mask_r <= wdata_r[`CCH_IRQ_W-1:0];
        end
      end
    end
  end

  // AXI write channel: take address and data in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      waddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
    end else begin
      s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        waddr_r <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        // Response after both halves arrived
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (waddr_r == `CCH_CTRL_OFS || waddr_r == `CCH_PRI_OFS ||
          waddr_r == `CCH_SEC_OFS || waddr_r == `CCH_STAT_OFS ||
          waddr_r == `CCH_MASK_OFS) ? 2'h0 : 2'h2;
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        // Address decode
        if ({s_axi_araddr[7:2], 2'b00} == `CCH_CTRL_OFS) begin
          s_axi_rdata <= {16'h0000, ctrl_r[15:5], flt_r, ctrl_r[3:0]};
        end else if ({s_axi_araddr[7:2], 2'b00} == `CCH_PRI_OFS) begin
          s_axi_rdata <= {16'h0000, pri_r};
        end else if ({s_axi_araddr[7:2], 2'b00} == `CCH_SEC_OFS) begin
          s_axi_rdata <= {16'h0000, sec_r};
        end else if ({s_axi_araddr[7:2], 2'b00} == `CCH_STAT_OFS) begin
          s_axi_rdata <= {29'h00000000, stat_r};
        end else if ({s_axi_araddr[7:2], 2'b00} == `CCH_MASK_OFS) begin
          s_axi_rdata <= {29'h00000000, mask_r};
        end else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'h2;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// File: logic/pin_sync.v
`timescale 1ns/1ps
`include "compare_channel_regs.vh"
// Three-stage synchroniser; level changes once stages two and three agree
module pin_sync (
  input wire aclk,
  input wire aresetn,
  input wire pin_in,
  output reg level_r
);
  // Synchroniser chain, first stage read only by second
  reg s1_r;
  reg s2_r;
  reg s3_r;
  // Shift and agree
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      level_r <= 1'b1;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // Accept only a settled level
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end
endmodule
